// ### rtl/svlc_coder.v
// Serial video line coder: word FIFO, LSB-first serializer, scrambler and NRZI stage.
// ****************************************************************
// Summary of operation
// - Scramble serial bits multiplicatively with polynomial x^9 + x^4 + 1.
// - Follow with x + 1 stage: each scrambled one toggles the line.
// - Serialize each 10-bit word least significant bit first.
// - NRZI line makes receiver polarity-independent; no absolute polarity fixed.
// - One bit per unit interval; ten bits emitted per input word.
// - Coding is content-independent, shaping spectrum and aiding clock recovery.
// - Input carries 3FF 000 000 preambles marking word boundaries.
// - Input words arrive as chroma-blue, luma, chroma-red, luma multiplex.
// ****************************************************************
`include "svlc_consts.vh"
module svlc_coder
(
    input wire CLK,
    input wire RSTN,
    input wire WORD_VALID,
    output wire WORD_READY,
    input wire [`SVLC_WORD_W-1:0] WORD_DATA,
    output reg SER_BIT,
    output reg SER_BIT_VALID,
    output reg WORD_START,
    output reg TRS_SEEN,
    output reg [`SVLC_PHASE_W-1:0] MUX_PHASE
);
    // ****************************************************************
    // Timing
    // ****************************************************************
    // The bit interval is emulated at one bit per clock; a real line needs a
    // bit clock of 3.7 ns, which this core clock cannot reach, so the stream is
    // produced at clock rate with a valid qualifier instead.

    // ****************************************************************
    // State encoding and storage
    // ****************************************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_SHIFT = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`SVLC_WORD_W-1:0] shreg_r;
    reg [`SVLC_WORD_W-1:0] shreg_nxt;
    reg [`SVLC_BIT_CNT_W-1:0] bitcnt_r;
    reg [`SVLC_BIT_CNT_W-1:0] bitcnt_nxt;
    reg [`SVLC_SCR_W-1:0] scr_r;
    reg [`SVLC_SCR_W-1:0] scr_nxt;
    reg [`SVLC_WORD_W-1:0] prev1_r;
    reg [`SVLC_WORD_W-1:0] prev1_nxt;
    reg [`SVLC_WORD_W-1:0] prev2_r;
    reg [`SVLC_WORD_W-1:0] prev2_nxt;
    reg line_nxt;
    reg bit_valid_nxt;
    reg word_start_nxt;
    reg trs_nxt;
    reg [`SVLC_PHASE_W-1:0] phase_nxt;
    reg loading;
    wire fifo_valid;
    wire fifo_ready;
    wire [`SVLC_WORD_W-1:0] fifo_data;
    wire data_bit;
    wire scr_bit;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // One scrambler step: the new symbol depends on the data bit and two earlier
    // symbols, so the far side can undo it without knowing where it started.
    function scramble;
        input d;
        input [`SVLC_SCR_W-1:0] hist;
        begin
            scramble = d ^ hist[`SVLC_SCR_TAP_A] ^ hist[`SVLC_SCR_TAP_B];
        end
    endfunction

    function is_last_bit;
        input [`SVLC_BIT_CNT_W-1:0] cnt;
        begin
            is_last_bit = (cnt == `SVLC_LAST_BIT);
        end
    endfunction

    // The preamble is matched on loaded words only, so it never spans a cut word.
    function is_preamble;
        input [`SVLC_WORD_W-1:0] older;
        input [`SVLC_WORD_W-1:0] newer;
        input [`SVLC_WORD_W-1:0] cur;
        begin
            is_preamble = (older == `SVLC_TRS_FIRST) && (newer == `SVLC_TRS_ZERO) &&
                (cur == `SVLC_TRS_ZERO);
        end
    endfunction

    // ****************************************************************
    // Input buffering
    // ****************************************************************
    svlc_fifo #(
        .WIDTH(`SVLC_WORD_W),
        .DEPTH(`SVLC_FIFO_DEPTH),
        .AW(`SVLC_FIFO_AW)
    ) u_fifo (
        .clk(CLK),
        .rstn(RSTN),
        .in_valid(WORD_VALID),
        .in_ready(WORD_READY),
        .in_data(WORD_DATA),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // While shifting, a new word is taken only as the last bit of the previous one leaves, so the
    // FIFO fills whenever the source outruns ten bits per word.
    always @*
    begin
        loading = 1'b0;
        case (state_r)
            ST_IDLE: loading = fifo_valid;
            ST_SHIFT: loading = fifo_valid && is_last_bit(bitcnt_r);
            default: loading = 1'b0;
        endcase
    end
    assign fifo_ready = loading;

    // ****************************************************************
    // Serializer and coder
    // ****************************************************************
    assign data_bit = shreg_r[0];
    assign scr_bit = scramble(data_bit, scr_r);

    // ****************************************************************
    // Next-value logic
    // ****************************************************************
    // A load overrides the shift: the last bit leaves while the next word enters.
    always @*
    begin
        state_nxt = state_r;
        shreg_nxt = shreg_r;
        bitcnt_nxt = bitcnt_r;
        scr_nxt = scr_r;
        prev1_nxt = prev1_r;
        prev2_nxt = prev2_r;
        line_nxt = SER_BIT;
        bit_valid_nxt = 1'b0;
        word_start_nxt = 1'b0;
        trs_nxt = 1'b0;
        phase_nxt = MUX_PHASE;
        if (state_r == ST_SHIFT)
        begin
            scr_nxt = {scr_r[`SVLC_SCR_W-2:0], scr_bit};
            line_nxt = SER_BIT ^ scr_bit;
            bit_valid_nxt = 1'b1;
            shreg_nxt = {1'b0, shreg_r[`SVLC_WORD_W-1:1]};
            bitcnt_nxt = bitcnt_r + 1'b1;
        end

        case (state_r)
            ST_IDLE:
            begin
                if (loading)
                begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (is_last_bit(bitcnt_r) && !loading)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase

        if (loading)
        begin
            shreg_nxt = fifo_data;
            bitcnt_nxt = {`SVLC_BIT_CNT_W{1'b0}};
            word_start_nxt = 1'b1;
            phase_nxt = MUX_PHASE + 1'b1;
            prev1_nxt = fifo_data;
            prev2_nxt = prev1_r;
            trs_nxt = is_preamble(prev2_r, prev1_r, fifo_data);
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Every output leaves from a flip-flop so the far side sees clean edges.
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state_r <= ST_IDLE;
            shreg_r <= {`SVLC_WORD_W{1'b0}};
            bitcnt_r <= {`SVLC_BIT_CNT_W{1'b0}};
            scr_r <= `SVLC_SCR_RESET;
            prev1_r <= {`SVLC_WORD_W{1'b0}};
            prev2_r <= {`SVLC_WORD_W{1'b0}};
            // The line resets low so a receiver starts from a known level.
            SER_BIT <= 1'b0;
            SER_BIT_VALID <= 1'b0;
            WORD_START <= 1'b0;
            TRS_SEEN <= 1'b0;
            MUX_PHASE <= {`SVLC_PHASE_W{1'b0}};
        end
        else
        begin
            state_r <= state_nxt;
            shreg_r <= shreg_nxt;
            bitcnt_r <= bitcnt_nxt;
            scr_r <= scr_nxt;
            prev1_r <= prev1_nxt;
            prev2_r <= prev2_nxt;
            SER_BIT <= line_nxt;
            SER_BIT_VALID <= bit_valid_nxt;
            WORD_START <= word_start_nxt;
            TRS_SEEN <= trs_nxt;
            MUX_PHASE <= phase_nxt;
        end
    end
endmodule

// ### rtl/svlc_consts.vh
// Constants shared by the serial video line coder design files.
`ifndef SVLC_CONSTS_VH
`define SVLC_CONSTS_VH
`define SVLC_WORD_W 10
`define SVLC_FIFO_DEPTH 8
`define SVLC_FIFO_AW 3
`define SVLC_BIT_CNT_W 4
`define SVLC_LAST_BIT 4'h9
`define SVLC_SCR_W 9
`define SVLC_SCR_TAP_A 8
`define SVLC_SCR_TAP_B 3
`define SVLC_SCR_RESET 9'h000
`define SVLC_UI_PS 3700
`define SVLC_CLK_PS 10000
`define SVLC_BIT_DIV 1
`define SVLC_TRS_FIRST 10'h3FF
`define SVLC_TRS_ZERO 10'h000
`define SVLC_PHASE_W 2
`endif

// ### rtl/svlc_fifo.v
// Word FIFO between the parallel multiplex input and the serializer.
`include "svlc_consts.vh"
module svlc_fifo
#(
    parameter WIDTH = `SVLC_WORD_W,
    parameter DEPTH = `SVLC_FIFO_DEPTH,
    parameter AW = `SVLC_FIFO_AW
)
(
    input wire clk,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wptr_r;
    reg [AW-1:0] rptr_r;
    reg [AW:0] count_r;
    reg [AW:0] count_nxt;
    reg ready_r;
    reg valid_r;
    wire push;
    wire pop;

    // Both flags leave from flip-flops; they are worked out from the next
    // count so that they still agree with the count in every cycle.
    assign in_ready = ready_r;
    assign out_valid = valid_r;
    assign out_data = mem_r[rptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wptr_r] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            ready_r <= 1'b1;
            valid_r <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop)
            begin
                rptr_r <= rptr_r + 1'b1;
            end
            count_r <= count_nxt;
            ready_r <= (count_nxt != DEPTH[AW:0]);
            valid_r <= (count_nxt != {(AW+1){1'b0}});
        end
    end

    always @*
    begin
        count_nxt = count_r;
        if (push && !pop)
        begin
            count_nxt = count_r + 1'b1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 1'b1;
        end
    end
endmodule

// ### tb/svlc_coder_tb_top.sv
// Testbench for the serial video line coder.
module svlc_coder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic word_valid = 1'b0;
    logic [9:0] word_data = 10'h000;
    wire word_ready, ser_bit, ser_valid, word_start, trs_seen, rx0_ok, rx1_ok;
    wire [1:0] mux_phase;
    wire [9:0] rx0_w, rx1_w;
    logic [9:0] exp_w [0:63];
    logic [31:0] rv;
    integer seed = 32'hdb42;
    integer err_count = 0, num_checks = 0, n_sent, n_load, n_take, r0, r1, i, b;
    always #5 clk = ~clk;
    svlc_coder svlc_coder_inst (.CLK(clk), .RSTN(rstn), .WORD_VALID(word_valid),
        .WORD_READY(word_ready), .WORD_DATA(word_data), .SER_BIT(ser_bit),
        .SER_BIT_VALID(ser_valid), .WORD_START(word_start), .TRS_SEEN(trs_seen),
        .MUX_PHASE(mux_phase));
    svlc_rx_model svlc_rx_model_inst (.clk(clk), .rstn(rstn), .line_in(ser_bit),
        .bit_valid(ser_valid), .word_r(rx0_w), .word_ok_r(rx0_ok));
    svlc_rx_model svlc_rx_model_inv_inst (.clk(clk), .rstn(rstn), .line_in(~ser_bit),
        .bit_valid(ser_valid), .word_r(rx1_w), .word_ok_r(rx1_ok));
    task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({9'h000, got}, {9'h000, exp});
    endtask
    function automatic logic trs_exp(input integer k);
        return k >= 3 && exp_w[k-3] == 10'h3FF && exp_w[k-2] == 10'h000 && exp_w[k-1] == 10'h000;
    endfunction
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Valid stays up between words so the FIFO fills while the line drains.
    task automatic send(input logic [9:0] w);
        exp_w[n_sent] = w;
        n_sent++;
        word_valid = 1'b1;
        word_data = w;
        for (b = 0; b < 200 && word_ready !== 1'b1; b++)
            @(posedge clk) #1;
        @(posedge clk) #1;
    endtask
    task automatic run_batch(input integer n);
        #1 rstn = 1'b0;
        n_sent = 0;
        n_load = 0;
        n_take = 0;
        r0 = 0;
        r1 = 0;
        repeat (16) @(posedge clk);
        #1 chk_word({3'h0, ser_bit, ser_valid, word_start, trs_seen, mux_phase, word_ready},
            10'h001);
        rstn = 1'b1;
        send(10'h3FF); send(10'h000); send(10'h000); send(10'h2D8);
        send(10'h3FF); send(10'h000); send(10'h200); send(10'h040);
        for (i = 0; i < n; i++)
        begin
            rv = $random(seed);
            send(rv[9:0]);
        end
        word_valid = 1'b0;
        for (i = 0; i < 3000 && (r0 < n_sent || r1 < n_sent); i++)
            @(posedge clk) #1;
        chk_word(r0[9:0], n_sent[9:0]);
        chk_word(r1[9:0], n_sent[9:0]);
    endtask
    always @(posedge clk)
    begin
        if (rx0_ok === 1'b1)
        begin
            chk_word(rx0_w, exp_w[r0]);
            r0++;
        end
        if (rx1_ok === 1'b1)
        begin
            chk_word(rx1_w, exp_w[r1]);
            r1++;
        end
        if (word_start === 1'b1)
        begin
            n_load++;
            chk_bit(trs_seen, trs_exp(n_load));
            chk_word({8'h00, mux_phase}, {8'h00, n_load[1:0]});
        end
        // Ready must drop exactly when eight accepted words are still waiting.
        if (rstn === 1'b1)
        begin
            chk_bit(word_ready, (n_take - n_load) != 8);
            if (word_valid === 1'b1 && word_ready === 1'b1)
                n_take++;
        end
    end
    initial
    begin
        run_batch(40);
        run_batch(16);
        test_done;
    end
    initial
    begin
        #100000;
        err_count++;
        test_done;
    end
endmodule
bind svlc_coder svlc_properties svlc_properties_inst (.CLK(CLK), .RSTN(RSTN),
    .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY), .WORD_DATA(WORD_DATA),
    .SER_BIT(SER_BIT), .SER_BIT_VALID(SER_BIT_VALID), .WORD_START(WORD_START),
    .TRS_SEEN(TRS_SEEN), .MUX_PHASE(MUX_PHASE));

// ### tb/svlc_properties.sv
// Port timing checker of the line coder.
module svlc_properties
(
    input wire CLK,
    input wire RSTN,
    input wire WORD_VALID,
    input wire WORD_READY,
    input wire [9:0] WORD_DATA,
    input wire SER_BIT,
    input wire SER_BIT_VALID,
    input wire WORD_START,
    input wire TRS_SEEN,
    input wire [1:0] MUX_PHASE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire take = WORD_VALID && WORD_READY;
    a_ten_bits: assert property (WORD_START |=> SER_BIT_VALID[*8] ##1 SER_BIT_VALID[*2])
        else $error("word shorter than ten bits");
    a_start_gap: assert property (WORD_START |=> !WORD_START[*8] ##1 !WORD_START)
        else $error("word load too early");
    a_toggle_valid: assert property ($changed(SER_BIT) |-> SER_BIT_VALID)
        else $error("line moved outside a bit");
    a_first_bit: assert property (take && !SER_BIT_VALID && !$past(SER_BIT_VALID)
        && !$past(take) && !WORD_START |-> ##2 WORD_START) else $error("first bit late");
    a_trs_load: assert property (TRS_SEEN |-> WORD_START)
        else $error("preamble flag without load");
    a_phase_step: assert property (MUX_PHASE - $past(MUX_PHASE) == {1'b0, WORD_START})
        else $error("phase count wrong");
    a_full_busy: assert property (!WORD_READY |-> SER_BIT_VALID)
        else $error("full while idle");
    a_valid_end: assert property ($fell(SER_BIT_VALID) |-> $past(WORD_START, 11))
        else $error("bit run not ten long");
    c_trs: cover property (TRS_SEEN);
    c_full: cover property (!WORD_READY);
    c_b2b: cover property (WORD_START ##10 WORD_START);
endmodule

// ### tb/svlc_rx_model.sv
// Far-side receiver model: line decode, descrambler, word assembly.
module svlc_rx_model
(
    input wire clk,
    input wire rstn,
    input wire line_in,
    input wire bit_valid,
    output reg [9:0] word_r,
    output reg word_ok_r
);
    timeunit 1ns;
    timeprecision 100ps;
    reg prev_r;
    reg [8:0] hist_r;
    reg [3:0] cnt_r;
    // Tracking the idle level every cycle makes an inverted line harmless.
    wire nrz = line_in ^ prev_r;
    wire dat = nrz ^ hist_r[8] ^ hist_r[3];
    always @(posedge clk)
    begin
        prev_r <= line_in;
        word_ok_r <= 1'b0;
        if (!rstn)
        begin
            hist_r <= 9'h000;
            cnt_r <= 4'h0;
        end
        else if (bit_valid)
        begin
            hist_r <= {hist_r[7:0], nrz};
            word_r <= {dat, word_r[9:1]};
            cnt_r <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
            word_ok_r <= (cnt_r == 4'h9);
        end
    end
endmodule
